/* verilog/lpwu_defs.vh */
// constants of the low-power exit warm-up sequencer
`ifndef LPWU_DEFS_VH
`define LPWU_DEFS_VH

// register byte offsets
`define LPWU_OSC_CTRL_OFF   12'h000
`define LPWU_STBY_OFF       12'h004
`define LPWU_WU_CTRL_OFF    12'h008
`define LPWU_STATUS_OFF     12'h00C

// oscillator_control_reg fields
`define LPWU_SEL_BIT        0
`define LPWU_HS_EN_BIT      1
`define LPWU_LS_EN_BIT      2
`define LPWU_LOWER_LSB      4
`define LPWU_LOWER_MSB      7
`define LPWU_UPPER_LSB      8
`define LPWU_UPPER_MSB      19
`define LPWU_LOWER_RST      4'hF
`define LPWU_UPPER_RST      12'hFFF
`define LPWU_HS_EN_RST      1'b1
`define LPWU_LS_EN_RST      1'b0

// standby register fields
`define LPWU_STBY_LSB       0
`define LPWU_STBY_MSB       2
`define LPWU_SLOW_BIT       3
`define LPWU_STBY_RST       3'h2

// warm-up control and status fields
`define LPWU_WU_START_BIT   0
`define LPWU_ST_MODE_LSB    0
`define LPWU_ST_MODE_MSB    2
`define LPWU_ST_BUSY_BIT    3
`define LPWU_ST_CLKEN_BIT   4
`define LPWU_ST_DONE_BIT    5
`define LPWU_ST_SHORT_BIT   6

// operating mode codes
`define LPWU_M_NORMAL       3'h0
`define LPWU_M_SLOW         3'h1
`define LPWU_M_STOP         3'h2
`define LPWU_M_SLEEP        3'h3
`define LPWU_M_LIGHT_IDLE_MODE        3'h4
`define LPWU_M_BSLEEP       3'h5
`define LPWU_M_BSTOP        3'h6

// least warm-up intervals and a PLL settle time, and the warm-up intervals' count at the bus clock
`define LPWU_CLK_NS         40
`define LPWU_LIGHT_IDLE_MODE_MIN_NS   100000
`define LPWU_BK_HS_MIN_NS   500000
`define LPWU_BK_LS_MIN_NS   2500000
`define LPWU_PLL_SETTLE_NS  200000
`define LPWU_LIGHT_IDLE_MODE_MIN_CYC  ((`LPWU_LIGHT_IDLE_MODE_MIN_NS + `LPWU_CLK_NS - 1) / `LPWU_CLK_NS)
`define LPWU_BK_HS_MIN_CYC  ((`LPWU_BK_HS_MIN_NS + `LPWU_CLK_NS - 1) / `LPWU_CLK_NS)
`define LPWU_BK_LS_MIN_CYC  ((`LPWU_BK_LS_MIN_NS + `LPWU_CLK_NS - 1) / `LPWU_CLK_NS)

`endif

/* verilog/lpwu_counter.v */
// warm-up interval counter driven by oscillator tick enables
`timescale 1ns/1ps
module lpwu_counter #(
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // control
  input  wire             start,
  input  wire             tick,
  input  wire [CNT_W-1:0] limit,
  // state
  output reg              busy_q,
  output reg              done_q
);

  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] lim_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= {CNT_W{1'b0}};
      lim_q  <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        // limit latched so a rewrite mid-interval cannot shorten it
        cnt_q  <= {CNT_W{1'b0}};
        lim_q  <= limit;
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        if (cnt_q == lim_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

/* verilog/lpwu_sequencer.v */
// low-power exit warm-up sequencer with APB register slave
`timescale 1ns/1ps
`include "lpwu_defs.vh"
module lpwu_sequencer #(
  parameter CNT_W        = 16,
  parameter MIN_LIGHT_IDLE_MODE    = `LPWU_LIGHT_IDLE_MODE_MIN_CYC,
  parameter MIN_BK_HS    = `LPWU_BK_HS_MIN_CYC,
  parameter MIN_BK_LS    = `LPWU_BK_LS_MIN_CYC
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready_q,
  output reg  [31:0] prdata_q,
  output reg         pslverr_q,
  // cpu and wake sources
  input  wire        standby_enter,
  input  wire        wake_pin,
  // oscillator pins
  input  wire        hs_osc_in,
  input  wire        ls_osc_in,
  // clock generator controls
  output reg         hs_osc_en_q,
  output reg         ls_osc_en_q,
  output reg         sys_clk_en_q,
  output reg  [2:0]  mode_q
);

  localparam [2:0] S_RUN  = 3'b001;
  localparam [2:0] S_LOWP = 3'b010;
  localparam [2:0] S_WARM = 3'b100;
  localparam       PC_W   = 17;

  // register file
  reg              sel_q;
  reg              hs_en_q;
  reg              ls_en_q;
  reg  [3:0]       lower_q;
  reg  [11:0]      upper_q;
  reg  [2:0]       stby_q;
  reg              slow_q;
  reg              done_q;
  reg              short_q;

  // sequencer state
  reg  [2:0]       state_q;
  reg  [2:0]       ret_q;
  reg              auto_q;
  reg              auto_ls_q;
  reg              manual_ls_q;
  reg  [PC_W-1:0]  pcyc_q;

  // synchronisers
  reg  [2:0]       wake_s_q;
  reg  [2:0]       hs_s_q;
  reg  [2:0]       ls_s_q;

  wire             wr_en;
  wire             rd_setup;
  wire             wu_busy;
  wire             wu_done;
  wire             wake_rise;
  wire             tick;
  wire             tick_ls;
  wire             man_start;
  reg              auto_start;
  wire [CNT_W-1:0] interval;
  reg  [31:0]      rd_val;
  reg              rd_hit;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `LPWU_OSC_CTRL_OFF) || (a == `LPWU_STBY_OFF) ||
               (a == `LPWU_WU_CTRL_OFF) || (a == `LPWU_STATUS_OFF);
    end
  endfunction

  // least pclk cycles for a return to the given mode from the given standby mode
  function [PC_W-1:0] min_cyc;
    input [2:0] from;
    input [2:0] to;
    begin
      if (from == `LPWU_M_LIGHT_IDLE_MODE)
        min_cyc = MIN_LIGHT_IDLE_MODE[PC_W-1:0];
      else if ((from == `LPWU_M_BSLEEP) || (from == `LPWU_M_BSTOP))
        min_cyc = (to == `LPWU_M_SLOW) ? MIN_BK_LS[PC_W-1:0] : MIN_BK_HS[PC_W-1:0];
      else
        min_cyc = {PC_W{1'b0}};
    end
  endfunction

  assign wr_en    = psel && penable && pready_q && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign interval = {upper_q, lower_q};

  // first stage feeds only the second; edges seen on stages two and three
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_s_q <= 3'b000;
      hs_s_q   <= 3'b000;
      ls_s_q   <= 3'b000;
    end else begin
      wake_s_q <= {wake_s_q[1:0], wake_pin};
      hs_s_q   <= {hs_s_q[1:0], hs_osc_in};
      ls_s_q   <= {ls_s_q[1:0], ls_osc_in};
    end
  end

  assign wake_rise = wake_s_q[1] && !wake_s_q[2];
  // oscillators assumed below a quarter of pclk so no edge is missed
  assign tick_ls   = auto_q ? auto_ls_q : manual_ls_q;
  assign tick      = tick_ls ? (ls_s_q[1] && !ls_s_q[2]) : (hs_s_q[1] && !hs_s_q[2]);
  assign man_start = wr_en && (paddr == `LPWU_WU_CTRL_OFF) &&
                     pwdata[`LPWU_WU_START_BIT] && (state_q == S_RUN) && !wu_busy;

  lpwu_counter #(
    .CNT_W   (CNT_W)
  ) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (auto_start || man_start),
    .tick    (tick),
    .limit   (interval),
    .busy_q  (wu_busy),
    .done_q  (wu_done)
  );

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q       <= 1'b0;
      hs_en_q     <= `LPWU_HS_EN_RST;
      ls_en_q     <= `LPWU_LS_EN_RST;
      lower_q     <= `LPWU_LOWER_RST;
      upper_q     <= `LPWU_UPPER_RST;
      stby_q      <= `LPWU_STBY_RST;
      slow_q      <= 1'b0;
      manual_ls_q <= 1'b0;
    end else begin
      if (wr_en && (paddr == `LPWU_OSC_CTRL_OFF)) begin
        sel_q   <= pwdata[`LPWU_SEL_BIT];
        hs_en_q <= pwdata[`LPWU_HS_EN_BIT];
        ls_en_q <= pwdata[`LPWU_LS_EN_BIT];
        lower_q <= pwdata[`LPWU_LOWER_MSB:`LPWU_LOWER_LSB];
        upper_q <= pwdata[`LPWU_UPPER_MSB:`LPWU_UPPER_LSB];
      end
      if (wr_en && (paddr == `LPWU_STBY_OFF)) begin
        stby_q <= pwdata[`LPWU_STBY_MSB:`LPWU_STBY_LSB];
        // run-mode switch only while running; software warms up first
        if (state_q == S_RUN)
          slow_q <= pwdata[`LPWU_SLOW_BIT];
      end
      if (man_start)
        manual_ls_q <= sel_q;
    end
  end

  // standby entry, wake and warm-up sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset returns to normal with the clock on and no warm-up
      state_q      <= S_RUN;
      sys_clk_en_q <= 1'b1;
      mode_q       <= `LPWU_M_NORMAL;
      ret_q        <= `LPWU_M_NORMAL;
      hs_osc_en_q  <= 1'b1;
      ls_osc_en_q  <= 1'b0;
      auto_q       <= 1'b0;
      auto_ls_q    <= 1'b0;
      auto_start   <= 1'b0;
      pcyc_q       <= {PC_W{1'b0}};
      short_q      <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      auto_start <= 1'b0;
      case (state_q)
        S_RUN: begin
          mode_q      <= slow_q ? `LPWU_M_SLOW : `LPWU_M_NORMAL;
          hs_osc_en_q <= hs_en_q;
          ls_osc_en_q <= ls_en_q;
          if (standby_enter && (stby_q >= `LPWU_M_STOP) && (stby_q <= `LPWU_M_BSTOP)) begin
            state_q      <= S_LOWP;
            mode_q       <= stby_q;
            ret_q        <= slow_q ? `LPWU_M_SLOW : `LPWU_M_NORMAL;
            sys_clk_en_q <= 1'b0;
            hs_osc_en_q  <= (stby_q == `LPWU_M_LIGHT_IDLE_MODE) ? hs_en_q : 1'b0;
            // slow-mode sleep keeps the low-speed oscillator alive
            ls_osc_en_q  <= ((stby_q == `LPWU_M_SLEEP) || (stby_q == `LPWU_M_BSLEEP) ||
                             (stby_q == `LPWU_M_LIGHT_IDLE_MODE)) ? (ls_en_q || slow_q) : 1'b0;
          end
        end
        S_LOWP: begin
          if (wake_rise) begin
            if ((mode_q == `LPWU_M_SLEEP) && (ret_q == `LPWU_M_SLOW)) begin
              state_q      <= S_RUN;
              sys_clk_en_q <= 1'b1;
              mode_q       <= ret_q;
            end else begin
              state_q     <= S_WARM;
              auto_start  <= 1'b1;
              auto_q      <= 1'b1;
              auto_ls_q   <= (ret_q == `LPWU_M_SLOW);
              hs_osc_en_q <= (ret_q == `LPWU_M_NORMAL) || hs_en_q;
              ls_osc_en_q <= (ret_q == `LPWU_M_SLOW) || ls_en_q;
              pcyc_q      <= {PC_W{1'b0}};
            end
          end
        end
        S_WARM: begin
          if (pcyc_q != {PC_W{1'b1}})
            pcyc_q <= pcyc_q + {{(PC_W-1){1'b0}}, 1'b1};
          if (wu_done) begin
            state_q      <= S_RUN;
            sys_clk_en_q <= 1'b1;
            mode_q       <= ret_q;
            auto_q       <= 1'b0;
            // flags an interval below the transition's documented least
            if (pcyc_q < min_cyc(mode_q, ret_q))
              short_q <= 1'b1;
          end
        end
        default: begin
          state_q      <= S_RUN;
          sys_clk_en_q <= 1'b1;
        end
      endcase
      // hardware set wins over a same-cycle software clear
      if (wu_done)
        done_q <= 1'b1;
      else if (wr_en && (paddr == `LPWU_STATUS_OFF) && pwdata[`LPWU_ST_DONE_BIT])
        done_q <= 1'b0;
      if (wr_en && (paddr == `LPWU_STATUS_OFF) && pwdata[`LPWU_ST_SHORT_BIT] &&
          !(wu_done && (state_q == S_WARM)))
        short_q <= 1'b0;
    end
  end

  // read mux
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = mapped(paddr);
    case (paddr)
      `LPWU_OSC_CTRL_OFF: begin
        rd_val[`LPWU_SEL_BIT]                     = sel_q;
        rd_val[`LPWU_HS_EN_BIT]                   = hs_en_q;
        rd_val[`LPWU_LS_EN_BIT]                   = ls_en_q;
        rd_val[`LPWU_LOWER_MSB:`LPWU_LOWER_LSB]   = lower_q;
        rd_val[`LPWU_UPPER_MSB:`LPWU_UPPER_LSB]   = upper_q;
      end
      `LPWU_STBY_OFF: begin
        rd_val[`LPWU_STBY_MSB:`LPWU_STBY_LSB]     = stby_q;
        rd_val[`LPWU_SLOW_BIT]                    = slow_q;
      end
      `LPWU_WU_CTRL_OFF: begin
        rd_val[`LPWU_WU_START_BIT]                = wu_busy;
      end
      `LPWU_STATUS_OFF: begin
        rd_val[`LPWU_ST_MODE_MSB:`LPWU_ST_MODE_LSB] = mode_q;
        rd_val[`LPWU_ST_BUSY_BIT]                 = wu_busy;
        rd_val[`LPWU_ST_CLKEN_BIT]                = sys_clk_en_q;
        rd_val[`LPWU_ST_DONE_BIT]                 = done_q;
        rd_val[`LPWU_ST_SHORT_BIT]                = short_q;
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
  end

  // apb answer: one access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !rd_hit;
      if (rd_setup)
        prdata_q <= rd_val;
      else if (psel && penable && pready_q)
        prdata_q <= 32'h00000000;
    end
  end

endmodule

/* verification/lpwu_sequencer_sva.sv */
// port checks for the warm-up sequencer
`timescale 1ns/1ps
module lpwu_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // register bus
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready_q,
  input wire [31:0] prdata_q,
  input wire        pslverr_q,
  // standby and clock controls
  input wire        standby_enter,
  input wire        wake_pin,
  input wire        hs_osc_en_q,
  input wire        ls_osc_en_q,
  input wire        sys_clk_en_q,
  input wire [2:0]  mode_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C;

  a_ready_setup: assert property (psel && !penable |=> pready_q)
    else $error("no answer one cycle after setup");
  a_ready_access: assert property (pready_q |-> psel && penable)
    else $error("ready outside an access");
  a_err_unmapped: assert property (pready_q |-> pslverr_q == !mapped)
    else $error("error flag disagrees with address map");
  a_err_zero: assert property (pready_q && pslverr_q |-> prdata_q == 32'h00000000)
    else $error("refused read returns data");
  a_gate_mode: assert property (!sys_clk_en_q |-> mode_q >= 3'h2 && mode_q <= 3'h6)
    else $error("clock gated outside standby");
  a_gate_cause: assert property ($fell(sys_clk_en_q) |-> $past(standby_enter))
    else $error("clock gated without standby request");
  a_wake_hold: assert property ($rose(wake_pin) && !sys_clk_en_q |=> !sys_clk_en_q [*2])
    else $error("clock opened before wake was synchronised");
  a_open_hs: assert property ($rose(sys_clk_en_q) && mode_q == 3'h0 |-> hs_osc_en_q)
    else $error("normal return without high-speed oscillator");
  a_open_ls: assert property ($rose(sys_clk_en_q) |-> mode_q <= 3'h1 &&
                              (mode_q == 3'h0 || ls_osc_en_q))
    else $error("return to a wrong mode or without low-speed oscillator");
  a_sleep_ls: assert property (mode_q == 3'h3 && $past(mode_q) == 3'h3 |-> $stable(ls_osc_en_q))
    else $error("low-speed enable changed during sleep");
endmodule

bind lpwu_sequencer lpwu_chk lpwu_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready_q(pready_q), .prdata_q(prdata_q), .pslverr_q(pslverr_q),
  .standby_enter(standby_enter), .wake_pin(wake_pin), .hs_osc_en_q(hs_osc_en_q),
  .ls_osc_en_q(ls_osc_en_q), .sys_clk_en_q(sys_clk_en_q), .mode_q(mode_q)
);

/* verification/lpwu_sequencer_bench.sv */
// self-checking bench for the warm-up sequencer
`timescale 1ns/1ps
`include "lpwu_defs.vh"
module lpwu_sequencer_bench;
  reg         pclk          = 1'b0;
  reg         presetn       = 1'b0;
  reg         psel          = 1'b0;
  reg         penable       = 1'b0;
  reg         pwrite        = 1'b0;
  reg  [11:0] paddr         = 12'h000;
  reg  [31:0] pwdata        = 32'h00000000;
  reg         standby_enter = 1'b0;
  reg         wake_pin      = 1'b0;
  reg  [3:0]  osc_q         = 4'h0;
  reg  [31:0] rd;
  reg         er;
  reg  [31:0] ls_bit        = 32'h00000000;
  wire        pready_q;
  wire [31:0] prdata_q;
  wire        pslverr_q;
  wire        hs_osc_en_q;
  wire        ls_osc_en_q;
  wire        sys_clk_en_q;
  wire [2:0]  mode_q;
  integer     n_mismatch    = 0;
  integer     total_checks  = 0;

  always #20 pclk = ~pclk;
  // oscillators kept at pclk/8 and pclk/16, inside the tick limit
  always @(posedge pclk) osc_q <= osc_q + 4'h1;

  lpwu_sequencer #(.CNT_W(16), .MIN_LIGHT_IDLE_MODE(100), .MIN_BK_HS(20), .MIN_BK_LS(40)) lpwu_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .prdata_q(prdata_q),
    .pslverr_q(pslverr_q), .standby_enter(standby_enter), .wake_pin(wake_pin),
    .hs_osc_in(osc_q[2]), .ls_osc_in(osc_q[3]), .hs_osc_en_q(hs_osc_en_q),
    .ls_osc_en_q(ls_osc_en_q), .sys_clk_en_q(sys_clk_en_q), .mode_q(mode_q)
  );

  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] x);
    begin
      total_checks = total_checks + 1;
      if (s !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0t seen %h expected %h", $time, s, x);
      end
    end
  endtask

  task bus(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready_q !== 1'b1 && k < 40);
      rd = prdata_q;
      er = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rchk(input [11:0] a, input [31:0] x, input e);
    begin
      bus(1'b0, a, 32'h00000000);
      chk(rd, x);
      chk({31'h0, er}, {31'h0, e});
    end
  endtask

  // hand-started warm-up on the selected oscillator, clock stays open
  task man;
    integer k;
    begin
      bus(1'b1, `LPWU_STATUS_OFF, 32'h00000020);
      bus(1'b1, `LPWU_OSC_CTRL_OFF, 32'h00000052 | ls_bit);
      bus(1'b1, `LPWU_WU_CTRL_OFF, 32'h00000001);
      bus(1'b0, `LPWU_WU_CTRL_OFF, 32'h00000000);
      chk(rd & 32'h1, 32'h1);
      chk({31'h0, sys_clk_en_q}, 32'h1);
      k = 0;
      while (rd[0] !== 1'b0 && k < 100) begin
        bus(1'b0, `LPWU_WU_CTRL_OFF, 32'h00000000);
        k = k + 1;
      end
      bus(1'b0, `LPWU_STATUS_OFF, 32'h00000000);
      chk(rd & 32'h38, 32'h30);
      $display("test manual warm-up done");
    end
  endtask

  task wu(input [2:0] code, input [15:0] iv, input slow, input integer per, input sh);
    integer n;
    begin
      bus(1'b1, `LPWU_STATUS_OFF, 32'h00000060);
      bus(1'b1, `LPWU_OSC_CTRL_OFF, {12'h000, iv, 4'h0} | ls_bit | 32'h00000002);
      bus(1'b1, `LPWU_STBY_OFF, {28'h0000000, slow, code});
      @(posedge pclk) standby_enter <= 1'b1;
      @(posedge pclk) standby_enter <= 1'b0;
      @(posedge pclk) #1;
      chk({28'h0, mode_q, sys_clk_en_q}, {28'h0, code, 1'b0});
      if (code == `LPWU_M_SLEEP && slow)
        chk({31'h0, ls_osc_en_q}, 32'h1);
      @(posedge pclk) wake_pin <= 1'b1;
      n = 0;
      while (sys_clk_en_q !== 1'b1 && n < 5000) begin
        @(posedge pclk);
        n = n + 1;
      end
      wake_pin <= 1'b0;
      // a window, since wake and oscillator phases are unrelated
      chk({31'h0, n >= iv * per && n <= (iv + 2) * per + 8}, 32'h1);
      chk({29'h0, mode_q}, {31'h0, slow});
      chk({31'h0, slow ? ls_osc_en_q : hs_osc_en_q}, 32'h1);
      rchk(`LPWU_STATUS_OFF, {25'h0, sh, per != 0, 4'h8, slow}, 1'b0);
      $display("test standby %0d done", code);
    end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`LPWU_OSC_CTRL_OFF, 32'h000FFFF2, 1'b0);
    rchk(`LPWU_STBY_OFF, 32'h00000002, 1'b0);
    rchk(`LPWU_STATUS_OFF, 32'h00000010, 1'b0);
    bus(1'b1, 12'h010, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    rchk(12'h010, 32'h00000000, 1'b1);
    $display("test reset done");
    wu(`LPWU_M_STOP, 16'h0005, 1'b0, 8, 1'b0);
    wu(`LPWU_M_SLEEP, 16'h0007, 1'b0, 8, 1'b0);
    wu(`LPWU_M_LIGHT_IDLE_MODE, 16'h0005, 1'b0, 8, 1'b1);
    wu(`LPWU_M_BSLEEP, 16'h001E, 1'b0, 8, 1'b0);
    wu(`LPWU_M_BSTOP, 16'h001E, 1'b0, 8, 1'b0);
    ls_bit = 32'h00000005;
    man;
    bus(1'b1, `LPWU_STBY_OFF, 32'h0000000A);
    rchk(`LPWU_STATUS_OFF, 32'h00000031, 1'b0);
    wu(`LPWU_M_STOP, 16'h0003, 1'b1, 16, 1'b0);
    wu(`LPWU_M_BSTOP, 16'h0032, 1'b1, 16, 1'b0);
    wu(`LPWU_M_SLEEP, 16'h0000, 1'b1, 0, 1'b0);
    ls_bit = 32'h00000004;
    man;
    bus(1'b1, `LPWU_STBY_OFF, 32'h00000002);
    bus(1'b0, `LPWU_STATUS_OFF, 32'h00000000);
    chk(rd & 32'h7, 32'h0);
    $display("test slow return done");
    close_out;
  end

  initial begin
    #(40 * 20000);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
